// File: hdl/adcc_defs.vh
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH
// register address and layout of converter_control
`define ADCC_CTRL_ADDR 8'hc0
`define ADCC_CTRL_RESET 8'h00
`define ADCC_BIT_EN 7
`define ADCC_BIT_DAC1 6
`define ADCC_BIT_RESULT_VALUE_REG 5
`define ADCC_BIT_DONE 4
`define ADCC_BIT_START 3
`define ADCC_BIT_RC 2
`define ADCC_BIT_CH_HI 1
`define ADCC_BIT_CH_LO 0
// timing in machine cycles and rc clocks; MC_DIV in ref_clk clocks per machine cycle
`define ADCC_CPU_CONV_MC 31
`define ADCC_SYNC_MIN_MC 3
`define ADCC_RC_CONV_CLKS 108
`define ADCC_MC_DIV 6
`endif

// File: hdl/adcc_sync.v
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// two-flop level synchroniser
// ------------------------------------------------------------
module adcc_sync (
  input wire ref_clk,
  input wire rst_n,
  input wire din,
  output reg dout
);
  reg meta_r; // first stage, read only by second stage
  // plain double-flop crossing
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: hdl/adcc_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.vh"
module adcc_ctrl #(
  parameter MC_DIV = `ADCC_MC_DIV,
  parameter CPU_MC = `ADCC_CPU_CONV_MC,
  parameter SYNC_MC = `ADCC_SYNC_MIN_MC,
  parameter RC_CLKS = `ADCC_RC_CONV_CLKS
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  output wire [7:0] sfr_rdata,
  input wire cpu_power_down,
  input wire rc_tick,
  input wire sar_cmp,
  input wire [7:0] dac1_value,
  output reg [7:0] sar_trial,
  output reg [1:0] channel_sel,
  output wire converter_power,
  output wire result_value_reg_drive,
  output wire [7:0] result_value_reg_level,
  output wire dac1_drive,
  output wire [7:0] dac1_level,
  output wire adc_irq
);
  // ------------------------------------------------------------
  // control register state
  // ------------------------------------------------------------
  reg en_r; // converter_enable
  reg dac1_r; // dac1_output_enable
  reg result_value_reg_r; // result_value_reg_output_enable
  reg done_r; // conversion_done_flag
  reg busy_r; // conversion_start_busy
  reg rc_r; // rc_clock_select
  reg [7:0] result_r; // result_value_reg
  reg [7:0] sar_r; // approximation register
  reg [3:0] bit_r; // bit under trial
  reg [2:0] mc_div_r; // machine cycle divider
  reg [7:0] cnt_r; // step counter
  reg syncd_r; // rc sync phase finished
  wire rc_tick_s; // rc tick in ref_clk domain
  reg rc_tick_d_r; // for edge detect after sync
  // ------------------------------------------------------------
  // derived strobes and request qualification
  // ------------------------------------------------------------
  wire wr_hit = sfr_wr && (sfr_addr == `ADCC_CTRL_ADDR);
  wire idle = !busy_r && !done_r;
  // machine cycle strobe; one synchronous domain end to end, so the
  // sequencer keeps step at any cpu clock up to the top rate
  wire mc_pulse = (mc_div_r == MC_DIV - 1);
  wire rc_pulse = rc_tick_s && !rc_tick_d_r;
  // advance pulse: machine cycles or rc edges
  wire step = rc_r ? (syncd_r ? rc_pulse : mc_pulse) : mc_pulse;
  // last step count: cpu mode ends on machine cycle CPU_MC; rc mode takes
  // one edge more, since the first edge after sync only lines up with the
  // free running oscillator and a conversion must not undercut RC_CLKS
  // whole periods
  wire [7:0] last_cnt = rc_r ? RC_CLKS[7:0] : CPU_MC[7:0] - 8'h01;
  wire start_req = wr_hit && sfr_wdata[`ADCC_BIT_START] && idle && en_r;
  // cpu clock mode aborts on power down; rc mode keeps going
  wire abort = busy_r && !rc_r && cpu_power_down;
  // ------------------------------------------------------------
  // bit resolution: keep the trial bit where the comparator agrees
  // ------------------------------------------------------------
  function [7:0] resolve;
    input [7:0] acc;
    input cmp;
    input [2:0] pos;
    begin
      resolve = acc | ({7'h00, cmp} << pos);
    end
  endfunction
  // rc tick crosses in through two flops before its edge is taken
  adcc_sync u_rc_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .din(rc_tick),
    .dout(rc_tick_s)
  );
  // ------------------------------------------------------------
  // machine cycle divider, one pulse per MC_DIV clocks
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mc_div_r <= 3'h0;
      rc_tick_d_r <= 1'b0;
    end else begin
      // delayed copy of the synchronised tick for the edge detect
      rc_tick_d_r <= rc_tick_s;
      // restart on start so machine cycles line up with the request
      if (mc_pulse || start_req) begin
        mc_div_r <= 3'h0;
      end else begin
        mc_div_r <= mc_div_r + 3'h1;
      end
    end
  end
  // ------------------------------------------------------------
  // register writes with hardware priority
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= 1'b0;
      dac1_r <= 1'b0;
      result_value_reg_r <= 1'b0;
      rc_r <= 1'b0;
      channel_sel <= 2'h0;
    end else if (wr_hit) begin
      // clear refused unless idle; set always accepted
      if (sfr_wdata[`ADCC_BIT_EN] || idle) begin
        en_r <= sfr_wdata[`ADCC_BIT_EN];
      end
      // dac1 enable has no interlock with the converter
      dac1_r <= sfr_wdata[`ADCC_BIT_DAC1];
      if (idle) begin
        result_value_reg_r <= sfr_wdata[`ADCC_BIT_RESULT_VALUE_REG];
        channel_sel <= sfr_wdata[1:0];
      end
      // clock source frozen mid-conversion to keep timing sane
      if (!busy_r) begin
        rc_r <= sfr_wdata[`ADCC_BIT_RC];
      end
    end
  end
  // ------------------------------------------------------------
  // conversion sequencer and flags
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      result_r <= 8'h00;
      sar_r <= 8'h00;
      bit_r <= 4'h0;
      cnt_r <= 8'h00;
      syncd_r <= 1'b0;
      sar_trial <= 8'h00;
    end else begin
      // done clear by software; completion set below wins
      if (wr_hit && !sfr_wdata[`ADCC_BIT_DONE]) begin
        done_r <= 1'b0;
      end
      if (start_req) begin
        // start: clear accumulator, first trial is the top bit
        busy_r <= 1'b1;
        sar_r <= 8'h00;
        bit_r <= 4'h7;
        cnt_r <= 8'h00;
        syncd_r <= 1'b0;
        sar_trial <= 8'h80;
      end else if (abort || (busy_r && !en_r)) begin
        // dropped conversion: no done flag, result left as it was
        busy_r <= 1'b0;
      end else if (busy_r && step) begin
        // rc mode: count sync machine cycles first
        if (rc_r && !syncd_r) begin
          if (cnt_r == SYNC_MC - 1) begin
            syncd_r <= 1'b1;
            cnt_r <= 8'h00;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end else if (cnt_r == last_cnt) begin
          // last step: latch result, swap busy for done
          busy_r <= 1'b0;
          done_r <= 1'b1;
          result_r <= resolve(sar_r, sar_cmp, bit_r[2:0]);
        end else begin
          cnt_r <= cnt_r + 8'h01;
          // resolve one bit every four steps, bit 0 at the last step
          if (((cnt_r + 8'h01) & 8'h03) == 8'h00 && bit_r != 4'h0) begin
            sar_r <= resolve(sar_r, sar_cmp, bit_r[2:0]);
            bit_r <= bit_r - 4'h1;
            // next trial: bits so far plus the next lower bit
            sar_trial <= resolve(sar_r, sar_cmp, bit_r[2:0]) |
                         (8'h01 << (bit_r[2:0] - 3'h1));
          end
        end
      end
    end
  end
  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // analog side enables follow the register bits
  assign converter_power = en_r;
  assign result_value_reg_drive = result_value_reg_r;
  assign result_value_reg_level = result_r;
  assign dac1_drive = dac1_r;
  // dac1 level passes straight through, no latch
  assign dac1_level = dac1_value;
  assign adc_irq = done_r;
  // read view in register bit order, independent of address
  assign sfr_rdata = {en_r, dac1_r, result_value_reg_r, done_r, busy_r, rc_r, channel_sel};
endmodule
`default_nettype wire

// File: tb/adcc_sar_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------
// analog core: comparator, rc clock
// ----------------------------------
module adcc_sar_model (
  input wire logic ref_clk,
  input wire logic [7:0] sar_trial,
  input wire logic [7:0] vin,
  output wire logic sar_cmp,
  output wire logic rc_tick
);
  logic [2:0] div = 3'h0; // rc runs at an eighth of ref_clk
  // high while the input is not below the trial code
  assign sar_cmp = vin >= sar_trial;
  assign rc_tick = div[2];
  // free running: the oscillator never stops
  always @(posedge ref_clk) div <= div + 3'h1;
endmodule
`default_nettype wire

// File: tb/adcc_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------
// control register checker
// ----------------------------------
module adcc_ctrl_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic cpu_power_down,
  input wire logic [7:0] dac1_value,
  input wire logic result_value_reg_drive,
  input wire logic [7:0] result_value_reg_level,
  input wire logic dac1_drive,
  input wire logic [7:0] dac1_level,
  input wire logic adc_irq
);
  wire w = sfr_wr && sfr_addr == 8'hc0; // write to control
  wire [7:0] r = sfr_rdata; // register view
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_irq; (adc_irq == r[4]) and (adc_irq && !w |=> adc_irq); endproperty
  a_irq: assert property (p_irq) else $error("irq level");
  property p_result_value_reg;
    (result_value_reg_drive == r[5]) and
    (w |=> result_value_reg_drive == ($past(r[3] || r[4]) ? $past(r[5]) : $past(sfr_wdata[5])));
  endproperty
  a_result_value_reg: assert property (p_result_value_reg) else $error("result_value_reg drive");
  property p_dac1;
    (dac1_level == dac1_value) and (w |=> dac1_drive == $past(sfr_wdata[6]));
  endproperty
  a_dac1: assert property (p_dac1) else $error("dac1");
  property p_en; r[7] && (r[3] || r[4]) && w |=> r[7]; endproperty
  a_en: assert property (p_en) else $error("enable cleared");
  property p_busy; r[3] && !r[4] && w |=> $stable(r[1:0]) && $stable(r[5]); endproperty
  a_busy: assert property (p_busy) else $error("busy write");
  property p_go; r[7] && !r[3] && !r[4] && w && sfr_wdata[7] && sfr_wdata[3] |=> r[3]; endproperty
  a_go: assert property (p_go) else $error("start");
  property p_done; $rose(r[4]) |-> $fell(r[3]); endproperty
  a_done: assert property (p_done) else $error("done");
  property p_hold; adc_irq && !w |=> $stable(result_value_reg_level); endproperty
  a_hold: assert property (p_hold) else $error("result");
  property p_cpu;
    disable iff (!rst_n || cpu_power_down) $rose(r[3]) && !r[2] |-> ##186 r[4];
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu time");
endmodule
`default_nettype wire

// File: tb/test_adc_control_and_timing.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------
// control block bench
// ----------------------------------
module test_adc_control_and_timing;
  logic ref_clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, cpu_power_down = 1'b0;
  logic [7:0] sfr_addr = 8'hc0, sfr_wdata = 8'h00, dac1_value = 8'h3c, vin = 8'h5a;
  wire [7:0] sfr_rdata, sar_trial, result_value_reg_level, dac1_level;
  wire [1:0] channel_sel;
  wire sar_cmp, rc_tick, converter_power, result_value_reg_drive, dac1_drive, adc_irq;
  int mismatches = 0, comparisons = 0, cyc = 0, n;
  always #5 ref_clk = ~ref_clk;
  adcc_ctrl i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .cpu_power_down(cpu_power_down), .rc_tick(rc_tick), .sar_cmp(sar_cmp),
    .dac1_value(dac1_value), .sar_trial(sar_trial), .channel_sel(channel_sel),
    .converter_power(converter_power), .result_value_reg_drive(result_value_reg_drive), .result_value_reg_level(result_value_reg_level),
    .dac1_drive(dac1_drive), .dac1_level(dac1_level), .adc_irq(adc_irq));
  adcc_sar_model i_sar (.ref_clk(ref_clk), .sar_trial(sar_trial), .vin(vin),
    .sar_cmp(sar_cmp), .rc_tick(rc_tick));
  // compare and report
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one register write, strobe held across one edge
  task automatic wr(input logic [7:0] d);
    @(negedge ref_clk);
    sfr_wr = 1'b1;
    sfr_wdata = d;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask
  // bounded wait for the done flag
  task automatic wait_done(input int s);
    n = s;
    while (adc_irq !== 1'b1 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  // cpu clock conversion with blocked writes
  task automatic t_cpu;
    wr(8'h80);
    chk("power", 8'h01, {7'h00, converter_power});
    repeat (1000) @(negedge ref_clk); // settle time
    wr(8'h8b);
    chk("channel", 8'h03, {6'h00, channel_sel});
    wr(8'h28);
    chk("busy reg", 8'h8b, sfr_rdata);
    wait_done(2);
    chk("cpu time", 8'h01, {7'h00, n >= 180 && n <= 190});
    chk("done reg", 8'h93, sfr_rdata);
    chk("result", 8'h5a, result_value_reg_level);
    wr(8'h83);
    chk("cleared", 8'h83, sfr_rdata);
    // cpu clock conversion dropped by power down
    wr(8'h88);
    cpu_power_down = 1'b1;
    repeat (2) @(negedge ref_clk);
    cpu_power_down = 1'b0;
    chk("abort reg", 8'h80, sfr_rdata);
  endtask
  // rc conversion through power down, then dac enables
  task automatic t_rc;
    wr(8'h84);
    vin = 8'ha5;
    wr(8'h8c);
    cpu_power_down = 1'b1;
    wait_done(0);
    cpu_power_down = 1'b0;
    chk("rc time", 8'h01, {7'h00, n >= 882 && n <= 920});
    chk("rc reg", 8'h94, sfr_rdata);
    chk("rc result", 8'ha5, result_value_reg_level);
    wr(8'h84);
    wr(8'h60);
    chk("dac reg", 8'h60, sfr_rdata);
    wr(8'h08);
    chk("no start", 8'h00, sfr_rdata);
    chk("power off", 8'h00, {7'h00, converter_power});
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    chk("reset", 8'h00, sfr_rdata);
    t_cpu();
    t_rc();
    give_verdict();
  end
endmodule
bind adcc_ctrl adcc_ctrl_sva i_sva (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .cpu_power_down(cpu_power_down), .dac1_value(dac1_value),
  .result_value_reg_drive(result_value_reg_drive), .result_value_reg_level(result_value_reg_level), .dac1_drive(dac1_drive),
  .dac1_level(dac1_level), .adc_irq(adc_irq));
`default_nettype wire
